// File: verif/lpt_ctrl_model.sv
// Behavioural memory controller that drives the timing core
module lpt_ctrl_model
	import lpt_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Command side
	output lpt_cmd_t cmd_o,
	output logic cke_o,
	output logic wl_sel_o,
	// Data side
	output logic [DQ_W-1:0] dq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wl_cnt;
	logic [DQ_W-1:0] wdat;

	initial begin
		cmd_o = '0;
		cke_o = 1'h1;
		wl_sel_o = 1'h0;
		dq_o = '0;
		wl_cnt = 4'h0;
		wdat = '0;
	end

	// One command slot per call; spacing is what the bench asks for
	task automatic send(input lpt_op_e_t op, input logic [2:0] bank = 3'h0, input logic ent = 1'h0,
		input logic ext = 1'h0, input logic [CA_W-1:0] ca = '0);
		@(negedge clk_i);
		cmd_o = '{valid: 1'h1, op: op, bank: bank, ca_enter: ent, ca_exit: ext, ca: ca};
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(negedge clk_i);
			cmd_o = '0;
		end
	endtask

	task automatic set_cke(input logic v);
		@(negedge clk_i);
		cmd_o = '0;
		cke_o = v;
	endtask

	// Write data goes out write latency cycles after the write
	always @(posedge clk_i) begin
		if (cmd_o.valid && cmd_o.op == OP_WR) begin
			wl_cnt <= wl_sel_o ? 4'(WL_HI) : 4'(WL_LO);
		end else if (wl_cnt != 4'h0) begin
			wl_cnt <= wl_cnt - 4'h1;
		end
	end

	// Data held one cycle only, toggling otherwise so the cycle after it never matches
	always @(negedge clk_i) begin
		dq_o <= (wl_cnt == 4'h1) ? wdat : ~dq_o;
	end
endmodule

// File: verif/lpt_timing_sva.sv
// Concurrent checks on the ports of the command timing core
module lpt_timing_sva
	import lpt_pkg::*;
#(
	parameter int DPD_CYC = 20
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Inputs
	input wire lpt_cmd_t CMD_I,
	input wire logic CKE_I,
	input wire logic WL_SEL_I,
	input wire logic [DQ_W-1:0] DQ_I,
	input wire logic ERR_CLR_I,
	// Outputs
	input wire logic [DQ_W-1:0] DQ_O,
	input wire logic DQ_OE_O,
	input wire logic [DQ_W-1:0] WDATA_O,
	input wire logic WDATA_VALID_O,
	input wire logic ODT_EN_O,
	input wire lpt_state_t STATE_O,
	input wire logic [ERR_W-1:0] ERR_O
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	chk_wl6_capture: assert property (
		CMD_I.valid && CMD_I.op == OP_WR && STATE_O == ST_IDLE && !WL_SEL_I
		|-> ##7 (WDATA_VALID_O && WDATA_O == $past(DQ_I))) else $error("Write data late at latency six");
	chk_wl8_capture: assert property (
		CMD_I.valid && CMD_I.op == OP_WR && STATE_O == ST_IDLE && WL_SEL_I
		|-> ##9 (WDATA_VALID_O && WDATA_O == $past(DQ_I))) else $error("Write data late at latency eight");
	chk_entry_odt_off: assert property (
		CMD_I.valid && STATE_O == ST_IDLE && (CMD_I.op inside {OP_PDE, OP_SRE, OP_DPDE})
		|=> !ODT_EN_O && STATE_O != ST_IDLE) else $error("Termination still on after entry");
	chk_exit_odt_on: assert property (
		CMD_I.valid && ((CMD_I.op == OP_PDX && STATE_O == ST_PD) || (CMD_I.op == OP_SRX && STATE_O == ST_SR)
		|| (CMD_I.op == OP_DPDX && STATE_O == ST_DPD)) |=> ODT_EN_O && STATE_O == ST_IDLE)
		else $error("Termination not back on after exit");
	chk_cal_result_out: assert property (
		CMD_I.valid && CMD_I.op == OP_CAL && STATE_O == ST_CA
		|=> DQ_OE_O && DQ_O == {{(DQ_W-CA_W){1'b0}}, $past(CMD_I.ca)}) else $error("Calibration result missing");
	chk_cal_release: assert property (
		CMD_I.valid && CMD_I.op == OP_MRW && CMD_I.ca_exit && STATE_O == ST_CA
		|=> !DQ_OE_O && STATE_O == ST_IDLE) else $error("Data pins still driven after exit");
	chk_mrr_gap_flag: assert property (
		(CMD_I.valid && CMD_I.op == OP_MRR) ##1 (CMD_I.valid && CMD_I.op != OP_NOP)
		|=> ERR_O[1]) else $error("Short gap after mode read not flagged");
	chk_err_sticky: assert property (
		!ERR_CLR_I |=> (ERR_O & $past(ERR_O)) == $past(ERR_O)) else $error("Violation flag lost");
endmodule

bind lpt_timing_core lpt_timing_sva #(.DPD_CYC(DPD_CYC)) u_sva (.CLK_I(CLK_I), .RST_N_I(RST_N_I),
	.CMD_I(CMD_I), .CKE_I(CKE_I), .WL_SEL_I(WL_SEL_I), .DQ_I(DQ_I), .ERR_CLR_I(ERR_CLR_I), .DQ_O(DQ_O),
	.DQ_OE_O(DQ_OE_O), .WDATA_O(WDATA_O), .WDATA_VALID_O(WDATA_VALID_O), .ODT_EN_O(ODT_EN_O),
	.STATE_O(STATE_O), .ERR_O(ERR_O));

// File: verif/testbench.sv
// Self-checking testbench of the command timing core
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import lpt_pkg::*;

	localparam int DPD_T = 20;

	logic clk, rst_n, err_clr, cke, wl_sel, dq_oe, wdata_vld, odt_en;
	lpt_cmd_t cmd;
	logic [DQ_W-1:0] dq_in, dq_out, wdata;
	lpt_state_t state;
	logic [ERR_W-1:0] err;
	int fails = 0;
	int check_count = 0;
	int cycles = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	lpt_ctrl_model m (.clk_i(clk), .cmd_o(cmd), .cke_o(cke), .wl_sel_o(wl_sel), .dq_o(dq_in));

	lpt_timing_core #(.DPD_CYC(DPD_T)) dut (.CLK_I(clk), .RST_N_I(rst_n), .CMD_I(cmd), .CKE_I(cke),
		.WL_SEL_I(wl_sel), .DQ_I(dq_in), .DQ_O(dq_out), .DQ_OE_O(dq_oe), .WDATA_O(wdata),
		.WDATA_VALID_O(wdata_vld), .ODT_EN_O(odt_en), .STATE_O(state), .ERR_CLR_I(err_clr), .ERR_O(err));

	task automatic stop_test();
		$display("Checks made %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			stop_test();
		end
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
			fails++;
		end
	endtask

	task automatic restart();
		m.idle(1);
		rst_n = 1'b0;
		m.idle(2);
		rst_n = 1'b1;
	endtask

	// First command, then second one k edges later, on both sides of the limit
	task automatic pair(input lpt_op_e_t op1, input lpt_op_e_t op2, input logic [2:0] b2, input int n, input int bn);
		for (int k = n - 1; k <= n; k++) begin
			restart();
			if (op1 == OP_PDX || op1 == OP_SRX) begin
				m.send(op1 == OP_PDX ? OP_PDE : OP_SRE);
				m.idle(4);
			end
			m.send(op1);
			m.idle(k - 1);
			m.send(op2, b2);
			m.idle(2);
			check(err, (k < n) ? (32'h1 << bn) : 32'h0);
		end
	endtask

	task automatic t_write(input logic wl);
		int wn;
		wn = wl ? 8 : 6;
		for (int k = wn + 3; k <= wn + 4; k++) begin
			restart();
			m.wl_sel_o = wl;
			m.wdat = 16'h5A00 | 16'(k);
			m.send(OP_WR);
			m.idle(wn);
			check(wdata_vld, 32'h0);
			m.idle(1);
			check({wdata_vld, wdata}, {1'b1, m.wdat});
			m.idle(k - wn - 2);
			m.send(OP_RD);
			m.idle(2);
			check(err, (k < wn + 4) ? 32'h800 : 32'h0);
		end
	endtask

	task automatic t_rc();
		for (int k = 7; k <= 8; k++) begin
			restart();
			m.send(OP_ACT);
			m.idle(1);
			m.send(OP_PRE);
			m.idle(k - 3);
			m.send(OP_ACT);
			m.idle(2);
			check(err, (k < 8) ? 32'h10 : 32'h0);
		end
	endtask

	task automatic t_faw();
		for (int k = 7; k <= 8; k++) begin
			restart();
			for (int b = 0; b < 4; b++) begin
				if (b > 0) begin
					m.idle(1);
				end
				m.send(OP_ACT, 3'(b));
			end
			m.idle(k - 7);
			m.send(OP_ACT, 3'h4);
			m.idle(2);
			check(err, (k < 8) ? 32'h3000 : 32'h0);
		end
	endtask

	task automatic t_pd();
		for (int k = 5; k <= 6; k++) begin
			restart();
			m.send(OP_PDE);
			m.idle(1);
			check({state, odt_en}, {ST_PD, 1'b0});
			m.idle(3);
			m.send(OP_PDX);
			m.idle(1);
			check({state, odt_en}, {ST_IDLE, 1'b1});
			m.idle(k - 2);
			m.send(OP_MRR);
			m.idle(2);
			check(err, (k < 6) ? 32'h4 : 32'h0);
		end
	endtask

	// Training walk; the short variant lands each gap one cycle early, except the gap before CKE goes high
	task automatic t_ca(input logic bad);
		int d;
		d = bad ? 1 : 0;
		restart();
		m.send(OP_MRW, 3'h0, 1'h1);
		m.idle(9 - d);
		m.set_cke(1'b0);
		m.idle(9 - d);
		m.send(OP_CAL, 3'h0, 1'h0, 1'h0, 10'h2A5);
		m.idle(1);
		check({dq_oe, dq_out}, {1'b1, 16'h02A5});
		m.idle(2 - d);
		m.send(OP_CAL, 3'h0, 1'h0, 1'h0, 10'h15A);
		m.idle(1);
		check({dq_oe, dq_out}, {1'b1, 16'h015A});
		m.idle(4);
		m.set_cke(1'b1);
		m.idle(9 - d);
		m.send(OP_MRW, 3'h0, 1'h0, 1'h1);
		m.idle(1);
		check({dq_oe, state}, {1'b0, ST_IDLE});
		m.idle(1);
		check(err, bad ? 32'h5E0000 : 32'h0);
	endtask

	task automatic t_clear();
		restart();
		m.send(OP_MRR);
		m.send(OP_ACT);
		m.idle(5);
		check(err, 32'h2);
		err_clr = 1'b1;
		m.idle(1);
		err_clr = 1'b0;
		m.idle(1);
		check(err, 32'h0);
	endtask

	initial begin
		rst_n = 1'b0;
		err_clr = 1'b0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		check({state, odt_en, dq_oe, wdata_vld, err}, {ST_IDLE, 1'b1, 26'h0});
		pair(OP_MRR, OP_ACT, 3'h0, 4, 1);
		pair(OP_ACT, OP_ACT, 3'h1, 2, 12);
		pair(OP_RD, OP_PRE, 3'h0, 4, 8);
		pair(OP_PRE, OP_ACT, 3'h0, 3, 9);
		pair(OP_PREA, OP_ACT, 3'h0, 3, 10);
		pair(OP_SRE, OP_SRX, 3'h0, 3, 5);
		pair(OP_SRX, OP_ACT, 3'h0, 14, 6);
		pair(OP_PDX, OP_ACT, 3'h0, 3, 7);
		pair(OP_DPDE, OP_DPDX, 3'h0, DPD_T, 14);
		t_write(1'b0);
		t_write(1'b1);
		t_rc();
		t_faw();
		t_pd();
		t_ca(1'b0);
		t_ca(1'b1);
		t_clear();
		stop_test();
	end
endmodule

// File: verilog/lpt_gap_timer.sv
// Countdown that stays busy for one cycle less than the loaded number
module lpt_gap_timer
	import lpt_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic start_i,
	input wire logic [CNT_W-1:0] load_i,
	// Status
	output logic busy_o
);

	logic [CNT_W-1:0] cnt_q;

	// Busy for load-1 cycles after the start edge
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q <= '0;
		end else if (start_i) begin
			cnt_q <= (load_i == '0) ? '0 : load_i - CNT_W'(1);
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - CNT_W'(1);
		end
	end

	assign busy_o = (cnt_q != '0);

endmodule

// File: verilog/lpt_pkg.sv
// Constants, types and helpers of the command timing core
// What this block does
// - Write data taken six or eight cycles later
// - Termination off within 12 ns of power down
// - Termination on within 12 ns of exit
// - Calibration results driven within 20 ns
package lpt_pkg;

	// ----------------------------------------------------------------
	// Clock and rounding
	// ----------------------------------------------------------------
	localparam int CLK_PS = 10000;

	function automatic int lpt_cyc_min(input int t_ps, input int floor_nck);
		int c;
		c = (t_ps + CLK_PS - 1) / CLK_PS;
		return (c > floor_nck) ? c : floor_nck;
	endfunction

	function automatic int lpt_cyc_max(input int t_ps);
		int c;
		c = t_ps / CLK_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// ----------------------------------------------------------------
	// Times as printed
	// ----------------------------------------------------------------
	localparam int MRR_NCK = 4;
	localparam int RCD_PS = 18000;
	localparam int RCD_NCK = 3;
	localparam int RAS_PS = 42000;
	localparam int RAS_NCK = 3;
	localparam int RPPB_PS = 18000;
	localparam int RPPB_NCK = 3;
	localparam int RPAB_PS = 21000;
	localparam int RPAB_NCK = 3;
	localparam int CKESR_PS = 15000;
	localparam int CKESR_NCK = 3;
	localparam int RFCAB_PS = 130000;
	localparam int XSR_EXTRA_PS = 10000;
	localparam int XSR_NCK = 2;
	localparam int XP_PS = 7500;
	localparam int XP_NCK = 3;
	localparam int RTP_PS = 7500;
	localparam int RTP_NCK = 4;
	localparam int WTR_PS = 7500;
	localparam int WTR_NCK = 4;
	localparam int RRD_PS = 10000;
	localparam int RRD_NCK = 2;
	localparam int FAW_PS = 50000;
	localparam int FAW_NCK = 8;
	localparam int DPD_US = 500;
	localparam int ODT_OFF_PS = 12000;
	localparam int ODT_ON_PS = 12000;
	localparam int ADR_PS = 20000;
	localparam int CAMRD_NCK = 20;
	localparam int CAENT_NCK = 10;
	localparam int CAEXT_NCK = 10;
	localparam int CACKEL_NCK = 10;
	localparam int CACD_EXTRA_NCK = 2;
	localparam int WL_LO = 6;
	localparam int WL_HI = 8;

	// ----------------------------------------------------------------
	// Derived cycle counts
	// ----------------------------------------------------------------
	localparam int MRR_CYC = MRR_NCK;
	localparam int XP_CYC = lpt_cyc_min(XP_PS, XP_NCK);
	localparam int MRRI_CYC = XP_CYC + lpt_cyc_min(RCD_PS, RCD_NCK);
	localparam int XSR_CYC = lpt_cyc_min(RFCAB_PS + XSR_EXTRA_PS, XSR_NCK);
	localparam int CKESR_CYC = lpt_cyc_min(CKESR_PS, CKESR_NCK);
	localparam int RTP_CYC = lpt_cyc_min(RTP_PS, RTP_NCK);
	localparam int WTR_CYC = lpt_cyc_min(WTR_PS, WTR_NCK);
	localparam int RRD_CYC = lpt_cyc_min(RRD_PS, RRD_NCK);
	localparam int FAW_CYC = lpt_cyc_min(FAW_PS, FAW_NCK);
	localparam int RPPB_CYC = lpt_cyc_min(RPPB_PS, RPPB_NCK);
	localparam int RPAB_CYC = lpt_cyc_min(RPAB_PS, RPAB_NCK);
	localparam int RCPB_CYC = lpt_cyc_min(RAS_PS, RAS_NCK) + RPPB_CYC;
	localparam int RCAB_CYC = lpt_cyc_min(RAS_PS, RAS_NCK) + RPAB_CYC;
	localparam int CACD_CYC = lpt_cyc_min(ADR_PS + CACD_EXTRA_NCK * CLK_PS, 1);
	localparam int ODT_OFF_CYC = lpt_cyc_max(ODT_OFF_PS);
	localparam int ODT_ON_CYC = lpt_cyc_max(ODT_ON_PS);
	localparam int ADR_CYC = lpt_cyc_max(ADR_PS);

	// ----------------------------------------------------------------
	// Widths, indices, reset values
	// ----------------------------------------------------------------
	localparam int CNT_W = 16;
	localparam int DQ_W = 16;
	localparam int CA_W = 10;
	localparam int BANKS = 8;
	localparam int FAW_ACTS = 4;
	localparam int ERR_W = 24;
	localparam logic ODT_RST = 1'h1;

	localparam int T_MRR = 0;
	localparam int T_XP = 1;
	localparam int T_MRRI = 2;
	localparam int T_XSR = 3;
	localparam int T_CKESR = 4;
	localparam int T_DPD = 5;
	localparam int T_WTR = 6;
	localparam int T_RRD = 7;
	localparam int T_CAMRD = 8;
	localparam int T_CAENT = 9;
	localparam int T_CAEXT = 10;
	localparam int T_CACKEL = 11;
	localparam int T_CACD = 12;
	localparam int T_RPAB = 13;
	localparam int NT = 14;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_NOP = 4'h0, OP_ACT = 4'h1, OP_RD = 4'h2, OP_WR = 4'h3,
		OP_PRE = 4'h4, OP_PREA = 4'h5, OP_MRW = 4'h6, OP_MRR = 4'h7,
		OP_REF = 4'h8, OP_SRE = 4'h9, OP_SRX = 4'hA, OP_PDE = 4'hB,
		OP_PDX = 4'hC, OP_DPDE = 4'hD, OP_DPDX = 4'hE, OP_CAL = 4'hF
	} lpt_op_e_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_PD = 3'h1, ST_SR = 3'h3, ST_DPD = 3'h2, ST_CA = 3'h6
	} lpt_state_t;

	typedef struct packed {
		logic valid;
		lpt_op_e_t op;
		logic [2:0] bank;
		logic ca_enter;
		logic ca_exit;
		logic [CA_W-1:0] ca;
	} lpt_cmd_t;

	function automatic logic lpt_is(input lpt_cmd_t c, input lpt_op_e_t op);
		return c.valid && (c.op == op);
	endfunction

endpackage

// File: verilog/lpt_timing_core.sv
// Command timing core: write latency, termination, calibration output, spacing checks
module lpt_timing_core
	import lpt_pkg::*;
#(
	parameter int DPD_CYC = lpt_cyc_min(DPD_US * 1000000, 1)
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_N_I,
	// Decoded command and clock enable
	input wire lpt_cmd_t CMD_I,
	input wire logic CKE_I,
	input wire logic WL_SEL_I,
	// Data pins
	input wire logic [DQ_W-1:0] DQ_I,
	output logic [DQ_W-1:0] DQ_O,
	output logic DQ_OE_O,
	// Captured write data
	output logic [DQ_W-1:0] WDATA_O,
	output logic WDATA_VALID_O,
	// Termination and state
	output logic ODT_EN_O,
	output lpt_state_t STATE_O,
	// Spacing violations
	input wire logic ERR_CLR_I,
	output logic [ERR_W-1:0] ERR_O
);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic any_cmd;
	logic is_act;
	logic is_rd;
	logic is_wr;
	logic is_pre;
	logic is_prea;
	logic is_mrr;
	logic is_cal;
	logic ca_enter;
	logic ca_exit;
	logic cke_q;
	logic cke_fall;
	logic cke_rise;
	logic [2:0] bank;

	assign any_cmd = CMD_I.valid && (CMD_I.op != OP_NOP);
	assign is_act = lpt_is(CMD_I, OP_ACT);
	assign is_rd = lpt_is(CMD_I, OP_RD);
	assign is_wr = lpt_is(CMD_I, OP_WR);
	assign is_pre = lpt_is(CMD_I, OP_PRE);
	assign is_prea = lpt_is(CMD_I, OP_PREA);
	assign is_mrr = lpt_is(CMD_I, OP_MRR);
	assign is_cal = lpt_is(CMD_I, OP_CAL);
	assign ca_enter = lpt_is(CMD_I, OP_MRW) && CMD_I.ca_enter;
	assign ca_exit = lpt_is(CMD_I, OP_MRW) && CMD_I.ca_exit;
	assign bank = CMD_I.bank;
	assign cke_fall = cke_q && !CKE_I;
	assign cke_rise = !cke_q && CKE_I;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			cke_q <= 1'h0;
		end else begin
			cke_q <= CKE_I;
		end
	end

	// ----------------------------------------------------------------
	// Power and training state
	// ----------------------------------------------------------------
	lpt_state_t st_q;
	lpt_state_t st_d;

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (lpt_is(CMD_I, OP_PDE)) st_d = ST_PD;
				else if (lpt_is(CMD_I, OP_SRE)) st_d = ST_SR;
				else if (lpt_is(CMD_I, OP_DPDE)) st_d = ST_DPD;
				else if (ca_enter) st_d = ST_CA;
			end
			ST_PD: begin
				if (lpt_is(CMD_I, OP_PDX)) st_d = ST_IDLE;
			end
			ST_SR: begin
				if (lpt_is(CMD_I, OP_SRX)) st_d = ST_IDLE;
			end
			ST_DPD: begin
				if (lpt_is(CMD_I, OP_DPDX)) st_d = ST_IDLE;
			end
			ST_CA: begin
				if (ca_exit) st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			st_q <= ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign STATE_O = st_q;

	// ----------------------------------------------------------------
	// Termination: one register stage, inside ODT_OFF_CYC and ODT_ON_CYC
	// ----------------------------------------------------------------
	logic odt_q;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			odt_q <= ODT_RST;
		end else if ((st_q != ST_IDLE) && (st_d == ST_IDLE) && (st_q != ST_CA)) begin
			odt_q <= 1'h1;
		end else if ((st_q == ST_IDLE) && (st_d != ST_IDLE) && (st_d != ST_CA)) begin
			odt_q <= 1'h0;
		end
	end

	assign ODT_EN_O = odt_q;

	// ----------------------------------------------------------------
	// Write latency pipeline
	// ----------------------------------------------------------------
	logic [WL_HI-1:0] wr_pipe_q;
	logic wr_tap;
	logic [DQ_W-1:0] wdata_q;
	logic wvalid_q;

	assign wr_tap = WL_SEL_I ? wr_pipe_q[WL_HI-1] : wr_pipe_q[WL_LO-1];

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wr_pipe_q <= '0;
		end else begin
			wr_pipe_q <= {wr_pipe_q[WL_HI-2:0], is_wr && (st_q == ST_IDLE)};
		end
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			wdata_q <= '0;
			wvalid_q <= 1'h0;
		end else begin
			wvalid_q <= wr_tap;
			if (wr_tap) wdata_q <= DQ_I;
		end
	end

	assign WDATA_O = wdata_q;
	assign WDATA_VALID_O = wvalid_q;

	// ----------------------------------------------------------------
	// Calibration results on the data pins, one cycle, inside ADR_CYC
	// ----------------------------------------------------------------
	logic [DQ_W-1:0] dq_q;
	logic dq_oe_q;

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			dq_q <= '0;
			dq_oe_q <= 1'h0;
		end else if ((st_q == ST_CA) && ca_exit) begin
			dq_oe_q <= 1'h0;
		end else if ((st_q == ST_CA) && is_cal) begin
			dq_q <= {{(DQ_W - CA_W){1'b0}}, CMD_I.ca};
			dq_oe_q <= 1'h1;
		end
	end

	assign DQ_O = dq_q;
	assign DQ_OE_O = dq_oe_q;

	// ----------------------------------------------------------------
	// Shared gap timers
	// ----------------------------------------------------------------
	logic [NT-1:0] t_start;
	logic [NT-1:0] t_busy;
	logic [CNT_W-1:0] t_load [NT];

	always_comb begin
		t_start = '0;
		t_start[T_MRR] = is_mrr;
		t_start[T_XP] = lpt_is(CMD_I, OP_PDX);
		t_start[T_MRRI] = lpt_is(CMD_I, OP_PDX);
		t_start[T_XSR] = lpt_is(CMD_I, OP_SRX);
		t_start[T_CKESR] = lpt_is(CMD_I, OP_SRE);
		t_start[T_DPD] = lpt_is(CMD_I, OP_DPDE);
		t_start[T_WTR] = wr_tap;
		t_start[T_RRD] = is_act;
		t_start[T_CAMRD] = ca_enter;
		t_start[T_CAENT] = cke_fall;
		t_start[T_CAEXT] = cke_rise;
		t_start[T_CACKEL] = ca_enter;
		t_start[T_CACD] = is_cal;
		t_start[T_RPAB] = is_prea;
		t_load[T_MRR] = CNT_W'(MRR_CYC);
		t_load[T_XP] = CNT_W'(XP_CYC);
		t_load[T_MRRI] = CNT_W'(MRRI_CYC);
		t_load[T_XSR] = CNT_W'(XSR_CYC);
		t_load[T_CKESR] = CNT_W'(CKESR_CYC);
		t_load[T_DPD] = CNT_W'(DPD_CYC);
		t_load[T_WTR] = CNT_W'(WTR_CYC);
		t_load[T_RRD] = CNT_W'(RRD_CYC);
		t_load[T_CAMRD] = CNT_W'(CAMRD_NCK);
		t_load[T_CAENT] = CNT_W'(CAENT_NCK);
		t_load[T_CAEXT] = CNT_W'(CAEXT_NCK);
		t_load[T_CACKEL] = CNT_W'(CACKEL_NCK);
		t_load[T_CACD] = CNT_W'(CACD_CYC);
		t_load[T_RPAB] = CNT_W'(RPAB_CYC);
	end

	for (genvar g = 0; g < NT; g++) begin : g_tmr
		lpt_gap_timer u_tmr (
			.clk_i(CLK_I),
			.rst_n_i(RST_N_I),
			.start_i(t_start[g]),
			.load_i(t_load[g]),
			.busy_o(t_busy[g])
		);
	end

	// ----------------------------------------------------------------
	// Per-bank timers
	// ----------------------------------------------------------------
	logic [BANKS-1:0] rcpb_busy;
	logic [BANKS-1:0] rcab_busy;
	logic [BANKS-1:0] rtp_busy;
	logic [BANKS-1:0] rp_busy;
	logic [BANKS-1:0] ab_closed_q;

	for (genvar b = 0; b < BANKS; b++) begin : g_bank
		logic hit;
		assign hit = (bank == 3'(b));
		lpt_gap_timer u_rcpb (
			.clk_i(CLK_I), .rst_n_i(RST_N_I), .start_i(is_act && hit),
			.load_i(CNT_W'(RCPB_CYC)), .busy_o(rcpb_busy[b])
		);
		lpt_gap_timer u_rcab (
			.clk_i(CLK_I), .rst_n_i(RST_N_I), .start_i(is_act && hit),
			.load_i(CNT_W'(RCAB_CYC)), .busy_o(rcab_busy[b])
		);
		lpt_gap_timer u_rtp (
			.clk_i(CLK_I), .rst_n_i(RST_N_I), .start_i(is_rd && hit),
			.load_i(CNT_W'(RTP_CYC)), .busy_o(rtp_busy[b])
		);
		lpt_gap_timer u_rp (
			.clk_i(CLK_I), .rst_n_i(RST_N_I), .start_i(is_pre && hit),
			.load_i(CNT_W'(RPPB_CYC)), .busy_o(rp_busy[b])
		);
		// Remembers which precharge closed the bank
		always_ff @(posedge CLK_I or negedge RST_N_I) begin
			if (!RST_N_I) begin
				ab_closed_q[b] <= 1'h0;
			end else if (is_prea) begin
				ab_closed_q[b] <= 1'h1;
			end else if (is_pre && hit) begin
				ab_closed_q[b] <= 1'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Activate window ring and last activated bank
	// ----------------------------------------------------------------
	logic [FAW_ACTS-1:0] faw_busy;
	logic [1:0] faw_ptr_q;
	logic [2:0] last_bank_q;

	for (genvar f = 0; f < FAW_ACTS; f++) begin : g_faw
		lpt_gap_timer u_faw (
			.clk_i(CLK_I), .rst_n_i(RST_N_I), .start_i(is_act && (faw_ptr_q == 2'(f))),
			.load_i(CNT_W'(FAW_CYC)), .busy_o(faw_busy[f])
		);
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			faw_ptr_q <= 2'h0;
			last_bank_q <= 3'h0;
		end else if (is_act) begin
			faw_ptr_q <= faw_ptr_q + 2'h1;
			last_bank_q <= bank;
		end
	end

	// ----------------------------------------------------------------
	// Violation flags, set wins over clear
	// ----------------------------------------------------------------
	logic [ERR_W-1:0] err_set;
	logic [ERR_W-1:0] err_q;

	always_comb begin
		err_set = '0;
		err_set[1] = any_cmd && t_busy[T_MRR];
		err_set[2] = is_mrr && t_busy[T_MRRI];
		err_set[4] = is_act && (rcpb_busy[bank] || (ab_closed_q[bank] && rcab_busy[bank]));
		err_set[5] = lpt_is(CMD_I, OP_SRX) && t_busy[T_CKESR];
		err_set[6] = any_cmd && t_busy[T_XSR];
		err_set[7] = any_cmd && t_busy[T_XP];
		err_set[8] = (is_pre && rtp_busy[bank]) || (is_prea && (|rtp_busy));
		err_set[9] = is_act && rp_busy[bank];
		err_set[10] = is_act && t_busy[T_RPAB];
		err_set[11] = is_rd && t_busy[T_WTR];
		err_set[12] = is_act && (bank != last_bank_q) && t_busy[T_RRD];
		err_set[13] = is_act && (&faw_busy);
		err_set[14] = lpt_is(CMD_I, OP_DPDX) && t_busy[T_DPD];
		err_set[17] = is_cal && t_busy[T_CAMRD];
		err_set[18] = is_cal && t_busy[T_CAENT];
		err_set[19] = ca_exit && t_busy[T_CAEXT];
		err_set[20] = cke_fall && t_busy[T_CACKEL];
		err_set[22] = is_cal && t_busy[T_CACD];
	end

	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			err_q <= '0;
		end else begin
			err_q <= (ERR_CLR_I ? '0 : err_q) | err_set;
		end
	end

	assign ERR_O = err_q;

endmodule
